// File: design/bod_pkg.sv
// Constants, opcodes and types shared by the instruction decoder
package bod_pkg;

  // Instruction word layout
  localparam int unsigned W_WORD = 16;
  localparam int unsigned W_ADDR = 12;
  localparam int unsigned W_TGT  = 20;

  // Top-nibble classes
  localparam logic [3:0] NIB_MOVE_FF = 4'hc;
  localparam logic [3:0] NIB_PREFIX = 4'hf;
  localparam logic [3:0] NIB_MISC   = 4'h6;
  localparam logic [3:0] NIB_BIT_LO = 4'h7;
  localparam logic [3:0] NIB_BIT_HI = 4'hb;

  // Control and literal prefixes
  localparam logic [4:0]  PFX_BRANCH = 5'h1a;
  localparam logic [4:0]  PFX_BCOND  = 5'h1c;
  localparam logic [6:0]  PFX_CALL   = 7'h76;
  localparam logic [7:0]  PFX_ABSOLUTE_JUMP   = 8'hef;
  localparam logic [4:0]  PFX_LIT    = 5'h01;
  localparam logic [6:0]  PFX_MUL    = 7'h01;
  localparam logic [14:0] PFX_RETURN = 15'h0009;
  localparam logic [15:0] WORD_NOP   = 16'h0000;

  // Byte-oriented six-bit opcodes
  localparam logic [5:0] OPC_ADD    = 6'h09;
  localparam logic [5:0] OPC_ADDC   = 6'h08;
  localparam logic [5:0] OPC_SUB    = 6'h17;
  localparam logic [5:0] OPC_SUBB   = 6'h16;
  localparam logic [5:0] OPC_RSUBB  = 6'h15;
  localparam logic [5:0] OPC_AND    = 6'h05;
  localparam logic [5:0] OPC_IOR    = 6'h04;
  localparam logic [5:0] OPC_XOR    = 6'h06;
  localparam logic [5:0] OPC_COM    = 6'h07;
  localparam logic [5:0] OPC_MOVE_F = 6'h14;
  localparam logic [5:0] OPC_INC    = 6'h0a;
  localparam logic [5:0] OPC_DEC    = 6'h01;
  localparam logic [5:0] OPC_DECSZ  = 6'h0b;
  localparam logic [5:0] OPC_DECSNZ = 6'h13;
  localparam logic [5:0] OPC_INCSZ  = 6'h0f;
  localparam logic [5:0] OPC_INCSNZ = 6'h12;
  localparam logic [5:0] OPC_RLC    = 6'h0d;
  localparam logic [5:0] OPC_RRC    = 6'h0c;
  localparam logic [5:0] OPC_RLN    = 6'h11;
  localparam logic [5:0] OPC_RRN    = 6'h10;
  localparam logic [5:0] OPC_SWAP   = 6'h0e;

  // Byte-oriented seven-bit opcodes
  localparam logic [6:0] OPC_CPEQ  = 7'h31;
  localparam logic [6:0] OPC_CPGT  = 7'h32;
  localparam logic [6:0] OPC_CPLT  = 7'h30;
  localparam logic [6:0] OPC_TSTZ  = 7'h33;
  localparam logic [6:0] OPC_CLR   = 7'h35;
  localparam logic [6:0] OPC_SET   = 7'h34;
  localparam logic [6:0] OPC_MOVE_W = 7'h37;
  localparam logic [6:0] OPC_NEG   = 7'h36;

  // Status flag mask {carry, digit carry, zero, overflow, negative}
  localparam logic [4:0] FM_NONE = 5'h00;
  localparam logic [4:0] FM_ALL  = 5'h1f;
  localparam logic [4:0] FM_ZN   = 5'h05;
  localparam logic [4:0] FM_CZN  = 5'h15;
  localparam logic [4:0] FM_Z    = 5'h04;

  // Cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // Address map of the data space
  localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
  localparam logic [3:0]  ACCESS_LO_BNK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BNK = 4'hf;
  localparam logic [11:0] PORT_FIRST    = 12'hf80;
  localparam logic [11:0] PORT_LAST     = 12'hf8f;
  localparam logic [11:0] TIMER0_ADDR   = 12'hfd6;

  // Register map (byte addresses) and fields
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_COUNT   = 8'h08;
  localparam int unsigned CTRL_BNK_LO = 0;
  localparam int unsigned CTRL_PSA    = 8;
  localparam int unsigned CTRL_EN     = 9;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0200;

  typedef enum logic [5:0] {
    OP_NOP    = 6'h00, OP_ADD    = 6'h01, OP_ADDC   = 6'h02, OP_SUB    = 6'h03,
    OP_SUBB   = 6'h04, OP_RSUBB  = 6'h05, OP_AND    = 6'h06, OP_IOR    = 6'h07,
    OP_XOR    = 6'h08, OP_COM    = 6'h09, OP_MOVE_F = 6'h0a, OP_INC    = 6'h0b,
    OP_DEC    = 6'h0c, OP_DECSZ  = 6'h0d, OP_DECSNZ = 6'h0e, OP_INCSZ  = 6'h0f,
    OP_INCSNZ = 6'h10, OP_CPEQ   = 6'h11, OP_CPGT   = 6'h12, OP_CPLT   = 6'h13,
    OP_TSTZ   = 6'h14, OP_CLR    = 6'h15, OP_SET    = 6'h16, OP_MOVE_W = 6'h17,
    OP_NEG    = 6'h18, OP_MUL    = 6'h19, OP_RLC    = 6'h1a, OP_RRC    = 6'h1b,
    OP_RLN    = 6'h1c, OP_RRN    = 6'h1d, OP_SWAP   = 6'h1e, OP_MOVE_FF = 6'h1f,
    OP_BIT    = 6'h20, OP_LIT    = 6'h21, OP_BRANCH = 6'h22, OP_BCOND  = 6'h23,
    OP_ABSOLUTE_JUMP   = 6'h24, OP_CALL   = 6'h25, OP_RETURN = 6'h26, OP_OTHER  = 6'h3f
  } bod_op_t;

  typedef enum logic [1:0] {
    ST_FETCH   = 2'b00,
    ST_OPERAND = 2'b01,
    ST_FLUSH   = 2'b10
  } bod_state_t;

endpackage : bod_pkg

// File: design/bod_decoder.sv
// Instruction decoder for the byte-oriented core, with APB control registers
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module bod_decoder
  import bod_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  input  wire logic              ce_in,
  // Program memory side
  input  wire logic [15:0]       instr_in,
  input  wire logic              instr_valid_in,
  input  wire logic              taken_in,
  // Decoded instruction
  output logic                   valid_out,
  output bod_op_t                op_out,
  output logic [15:0]            word_out,
  output logic                   dest_file_out,
  output logic [11:0]            file_addr_out,
  output logic [11:0]            dst_addr_out,
  output logic [2:0]             bit_pos_out,
  output logic [7:0]             literal_out,
  output logic [19:0]            target_out,
  output logic [10:0]            offset_out,
  output logic [4:0]             flag_mask_out,
  output logic [1:0]             cycles_out,
  output logic                   skip_test_out,
  output logic                   shadow_save_out,
  output logic                   shadow_restore_out,
  output logic                   pin_read_out,
  output logic                   prescaler_clear_out,
  // APB slave
  input  wire logic [7:0]        paddr_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out
);

  function automatic bod_op_t decode_op(input logic [15:0] w);
    bod_op_t o;
    o = OP_OTHER;
    if (w[15:12] == NIB_MOVE_FF) begin
      o = OP_MOVE_FF;
    end else if (w[15:12] == NIB_PREFIX) begin
      o = OP_NOP;
    end else if (w[15:12] == NIB_MISC) begin
      case (w[15:9])
        OPC_CPEQ:  o = OP_CPEQ;
        OPC_CPGT:  o = OP_CPGT;
        OPC_CPLT:  o = OP_CPLT;
        OPC_TSTZ:  o = OP_TSTZ;
        OPC_CLR:   o = OP_CLR;
        OPC_SET:   o = OP_SET;
        OPC_MOVE_W: o = OP_MOVE_W;
        OPC_NEG:   o = OP_NEG;
        default:   o = OP_OTHER;
      endcase
    end else if (w[15:12] >= NIB_BIT_LO && w[15:12] <= NIB_BIT_HI) begin
      o = OP_BIT;
    end else if (w[15:11] == PFX_BRANCH) begin
      o = OP_BRANCH;
    end else if (w[15:11] == PFX_BCOND) begin
      o = OP_BCOND;
    end else if (w[15:9] == PFX_CALL) begin
      o = OP_CALL;
    end else if (w[15:8] == PFX_ABSOLUTE_JUMP) begin
      o = OP_ABSOLUTE_JUMP;
    end else if (w[15:11] == PFX_LIT) begin
      o = OP_LIT;
    end else if (w[15:9] == PFX_MUL) begin
      o = OP_MUL;
    end else if (w == WORD_NOP) begin
      o = OP_NOP;
    end else if (w[15:1] == PFX_RETURN) begin
      o = OP_RETURN;
    end else begin
      case (w[15:10])
        OPC_ADD:    o = OP_ADD;
        OPC_ADDC:   o = OP_ADDC;
        OPC_SUB:    o = OP_SUB;
        OPC_SUBB:   o = OP_SUBB;
        OPC_RSUBB:  o = OP_RSUBB;
        OPC_AND:    o = OP_AND;
        OPC_IOR:    o = OP_IOR;
        OPC_XOR:    o = OP_XOR;
        OPC_COM:    o = OP_COM;
        OPC_MOVE_F: o = OP_MOVE_F;
        OPC_INC:    o = OP_INC;
        OPC_DEC:    o = OP_DEC;
        OPC_DECSZ:  o = OP_DECSZ;
        OPC_DECSNZ: o = OP_DECSNZ;
        OPC_INCSZ:  o = OP_INCSZ;
        OPC_INCSNZ: o = OP_INCSNZ;
        OPC_RLC:    o = OP_RLC;
        OPC_RRC:    o = OP_RRC;
        OPC_RLN:    o = OP_RLN;
        OPC_RRN:    o = OP_RRN;
        OPC_SWAP:   o = OP_SWAP;
        default:    o = OP_OTHER;
      endcase
    end
    return o;
  endfunction : decode_op

  // Ops carrying a destination bit
  function automatic logic has_dest(input bod_op_t o);
    return (o >= OP_ADD && o <= OP_INCSNZ) || (o >= OP_RLC && o <= OP_SWAP);
  endfunction : has_dest

  // Single-word ops carrying bank-access bit and file address
  function automatic logic is_file_op(input bod_op_t o);
    return (o >= OP_ADD && o <= OP_SWAP) || o == OP_BIT;
  endfunction : is_file_op

  function automatic logic is_skip(input bod_op_t o);
    return (o >= OP_DECSZ && o <= OP_TSTZ);
  endfunction : is_skip

  function automatic logic [4:0] flags_of(input bod_op_t o);
    logic [4:0] m;
    m = FM_NONE;
    case (o)
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_RSUBB: m = FM_ALL;
      OP_INC, OP_DEC, OP_NEG:                     m = FM_ALL;
      OP_AND, OP_IOR, OP_XOR, OP_COM, OP_MOVE_F:  m = FM_ZN;
      OP_RLN, OP_RRN:                             m = FM_ZN;
      OP_RLC, OP_RRC:                             m = FM_CZN;
      OP_CLR:                                     m = FM_Z;
      default:                                    m = FM_NONE;
    endcase
    return m;
  endfunction : flags_of

  function automatic logic [11:0] eff_addr(input logic a, input logic [7:0] f,
                                           input logic [3:0] sel);
    logic [3:0] bank;
    bank = (f < ACCESS_SPLIT) ? ACCESS_LO_BNK : ACCESS_HI_BNK;
    if (a) begin
      bank = sel;
    end
    return {bank, f};
  endfunction : eff_addr

  // Control register and state
  logic [31:0]  ctrl_r;
  logic [15:0]  count_r;
  bod_state_t   state_r;
  bod_state_t   state_nxt;
  logic [15:0]  first_r;
  logic [3:0]   bank_sel;
  logic         dec_en;
  logic         psa;
  logic         take;
  logic         emit;
  bod_op_t      op_nxt;
  logic         dest_nxt;
  logic [11:0]  addr_nxt;
  logic         writes_file;

  assign bank_sel = ctrl_r[CTRL_BNK_LO +: 4];
  assign psa    = ctrl_r[CTRL_PSA];
  assign dec_en = ctrl_r[CTRL_EN];
  assign take   = ce_in && instr_valid_in;

  // Next decode from the current word and sequencing state
  always_comb begin
    state_nxt = state_r;
    emit      = 1'b0;
    op_nxt    = OP_NOP;
    dest_nxt  = 1'b0;
    addr_nxt  = '0;
    if (take) begin
      case (state_r)
        ST_FETCH: begin
          op_nxt = decode_op(instr_in);
          if (!dec_en || taken_in) begin
            op_nxt = OP_NOP;
            emit   = 1'b1;
          end else if (op_nxt == OP_MOVE_FF || op_nxt == OP_ABSOLUTE_JUMP || op_nxt == OP_CALL) begin
            state_nxt = ST_OPERAND;
          end else begin
            emit = 1'b1;
            if (op_nxt == OP_BRANCH) begin
              state_nxt = ST_FLUSH;
            end
          end
        end
        ST_OPERAND: begin
          op_nxt    = decode_op(first_r);
          emit      = 1'b1;
          state_nxt = (op_nxt == OP_MOVE_FF) ? ST_FETCH : ST_FLUSH;
        end
        ST_FLUSH: begin
          op_nxt    = OP_NOP;
          emit      = 1'b1;
          state_nxt = ST_FETCH;
        end
        default: begin
          state_nxt = ST_FETCH;
        end
      endcase
    end else if (ce_in && taken_in && state_r == ST_FETCH) begin
      state_nxt = ST_FLUSH;
    end
    if (is_file_op(op_nxt) && state_r == ST_FETCH) begin
      addr_nxt = eff_addr(instr_in[8], instr_in[7:0], bank_sel);
      dest_nxt = has_dest(op_nxt) ? instr_in[9] : (op_nxt >= OP_CLR && op_nxt <= OP_NEG);
    end else if (op_nxt == OP_MOVE_FF) begin
      addr_nxt = first_r[11:0];
      dest_nxt = 1'b1;
    end
  end

  assign writes_file = dest_nxt && (op_nxt != OP_BIT || instr_in[15:12] != NIB_BIT_LO + 4'h3);

  // Sequencing state and held first word
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= ST_FETCH;
      first_r <= '0;
    end else if (ce_in) begin
      state_r <= state_nxt;
      if (take && state_r == ST_FETCH) begin
        first_r <= instr_in;
      end
    end
  end

  // Decoded outputs
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      valid_out           <= 1'b0;
      op_out              <= OP_NOP;
      word_out            <= '0;
      dest_file_out       <= 1'b0;
      file_addr_out       <= '0;
      dst_addr_out        <= '0;
      bit_pos_out         <= '0;
      literal_out         <= '0;
      target_out          <= '0;
      offset_out          <= '0;
      flag_mask_out       <= FM_NONE;
      cycles_out          <= CYC_ONE;
      skip_test_out       <= 1'b0;
      shadow_save_out     <= 1'b0;
      shadow_restore_out  <= 1'b0;
      pin_read_out        <= 1'b0;
      prescaler_clear_out <= 1'b0;
    end else if (ce_in) begin
      valid_out           <= emit;
      pin_read_out        <= 1'b0;
      prescaler_clear_out <= 1'b0;
      if (emit) begin
        op_out          <= op_nxt;
        word_out        <= instr_in;
        dest_file_out   <= dest_nxt;
        file_addr_out   <= addr_nxt;
        dst_addr_out    <= (op_nxt == OP_MOVE_FF) ? instr_in[11:0] : addr_nxt;
        bit_pos_out     <= instr_in[11:9];
        literal_out     <= instr_in[7:0];
        target_out      <= {instr_in[11:0], first_r[7:0]};
        offset_out      <= (op_nxt == OP_BRANCH) ? instr_in[10:0]
                           : {{3{instr_in[7]}}, instr_in[7:0]};
        flag_mask_out   <= flags_of(op_nxt);
        cycles_out      <= (op_nxt inside {OP_MOVE_FF, OP_ABSOLUTE_JUMP, OP_CALL, OP_BRANCH, OP_RETURN})
                           ? CYC_TWO : CYC_ONE;
        skip_test_out   <= is_skip(op_nxt);
        shadow_save_out <= (op_nxt == OP_CALL) && first_r[8];
        shadow_restore_out <= (op_nxt == OP_RETURN) && instr_in[0];
        pin_read_out    <= writes_file && addr_nxt >= PORT_FIRST && addr_nxt <= PORT_LAST
                           && !(op_nxt inside {OP_CLR, OP_SET, OP_MOVE_W, OP_MOVE_FF});
        prescaler_clear_out <= psa && writes_file && addr_nxt == TIMER0_ADDR;
        if (op_nxt == OP_MOVE_FF) begin
          prescaler_clear_out <= psa && instr_in[11:0] == TIMER0_ADDR;
        end
      end
    end
  end

  // Emitted instruction counter
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      count_r <= '0;
    end else if (ce_in && emit) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // APB slave, one wait state
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl_r      <= CTRL_RESET;
      pready_out  <= 1'b0;
      prdata_out  <= '0;
      pslverr_out <= 1'b0;
    end else if (ce_in) begin
      pready_out  <= psel_in && penable_in && !pready_out;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
      if (psel_in && penable_in && !pready_out) begin
        case (paddr_in)
          REG_CTRL:   prdata_out <= ctrl_r;
          REG_STATUS: prdata_out <= {22'h0, state_r, 2'h0, op_out};
          REG_COUNT:  prdata_out <= {16'h0, count_r};
          default:    pslverr_out <= 1'b1;
        endcase
      end
      if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == REG_CTRL) begin
        ctrl_r <= {22'h0, pwdata_in[CTRL_EN], pwdata_in[CTRL_PSA], 4'h0,
                   pwdata_in[CTRL_BNK_LO +: 4]};
      end
    end
  end

  // Checks
  property p_dest;
    @(posedge mclk_in) disable iff (rst_in)
      valid_out && (op_out inside {OP_ADD, OP_SUB, OP_MOVE_F}) |-> dest_file_out == word_out[9];
  endproperty
  a_dest: assert property (p_dest) else $error("destination bit not honoured");

  property p_access;
    @(posedge mclk_in) disable iff (rst_in)
      valid_out && (op_out inside {OP_ADD, OP_CLR, OP_BIT}) && !word_out[8]
      |-> file_addr_out[11:8] == (word_out[7:0] < ACCESS_SPLIT ? ACCESS_LO_BNK : ACCESS_HI_BNK);
  endproperty
  a_access: assert property (p_access) else $error("access bank not selected");

  property p_faddr;
    @(posedge mclk_in) disable iff (rst_in)
      valid_out && (op_out inside {OP_XOR, OP_CPEQ, OP_BIT}) |-> file_addr_out[7:0] == word_out[7:0];
  endproperty
  a_faddr: assert property (p_faddr) else $error("file address mismatch");

  property p_move_ff;
    @(posedge mclk_in) disable iff (rst_in)
      valid_out && op_out == OP_MOVE_FF
      |-> cycles_out == CYC_TWO && flag_mask_out == FM_NONE && dst_addr_out == word_out[11:0];
  endproperty
  a_move_ff: assert property (p_move_ff) else $error("file move decode wrong");

  property p_bitpos;
    @(posedge mclk_in) disable iff (rst_in)
      valid_out && op_out == OP_BIT |-> bit_pos_out == word_out[11:9];
  endproperty
  a_bitpos: assert property (p_bitpos) else $error("bit position wrong");

  property p_absolute_jump;
    @(posedge mclk_in) disable iff (rst_in)
      valid_out && op_out == OP_ABSOLUTE_JUMP
      |-> target_out[19:8] == word_out[11:0] && state_r == ST_FLUSH;
  endproperty
  a_absolute_jump: assert property (p_absolute_jump) else $error("jump target or flush wrong");

  property p_arith;
    @(posedge mclk_in) disable iff (rst_in)
      valid_out && (op_out inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_RSUBB, OP_INC})
      |-> flag_mask_out == FM_ALL;
  endproperty
  a_arith: assert property (p_arith) else $error("arithmetic flag mask wrong");

  property p_skip;
    @(posedge mclk_in) disable iff (rst_in)
      valid_out && skip_test_out |-> flag_mask_out == FM_NONE && cycles_out == CYC_ONE;
  endproperty
  a_skip: assert property (p_skip) else $error("skip op touches flags");

  property p_branch;
    @(posedge mclk_in) disable iff (rst_in)
      ce_in && state_r == ST_FETCH && instr_valid_in && dec_en && !taken_in
      && instr_in[15:11] == PFX_BRANCH |=> state_r == ST_FLUSH && valid_out && cycles_out == CYC_TWO;
  endproperty
  a_branch: assert property (p_branch) else $error("branch not followed by flush");

  property p_stray;
    @(posedge mclk_in) disable iff (rst_in)
      ce_in && state_r == ST_FETCH && instr_valid_in && instr_in[15:12] == NIB_PREFIX
      |=> valid_out && op_out == OP_NOP;
  endproperty
  a_stray: assert property (p_stray) else $error("stray second word not a no-op");

  property p_timer0;
    @(posedge mclk_in) disable iff (rst_in)
      prescaler_clear_out |-> valid_out && $past(psa);
  endproperty
  a_timer0: assert property (p_timer0) else $error("prescaler clear without cause");

endmodule : bod_decoder

// File: verif/bod_prog_mem.sv
// Program memory model feeding instruction words to the decoder
`timescale 1ns/1ps
module bod_prog_mem (
  // Clock, reset, enable
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // Fetch limit and word output
  input  wire logic [8:0]  end_in,
  output logic      [15:0] instr_out,
  output logic             valid_out
);
  logic [15:0] mem [512];
  logic [8:0]  ptr_r;
  // One word per enabled cycle; idle bus toggles
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ptr_r     <= 9'h000;
      valid_out <= 1'b0;
      instr_out <= 16'h5a5a;
    end else if (ce_in) begin
      valid_out <= ptr_r != end_in;
      instr_out <= (ptr_r != end_in) ? mem[ptr_r] : ~instr_out;
      if (ptr_r != end_in) ptr_r <= ptr_r + 9'h001;
    end
  end
endmodule : bod_prog_mem

// File: verif/tb.sv
// Bench: reference decoder model, program memory and APB master
`timescale 1ns/1ps
module tb;
  import bod_pkg::*;
  typedef struct {bod_op_t op; logic [4:0] m; logic d; logic [11:0] fa; logic [19:0] x;
    int kd; logic pin; logic psc; logic skp; logic sv; logic [1:0] cy;} bod_exp_t;
  logic mclk_in = 0, rst_in = 1, ce_in = 1, taken_in = 0, rce = 0, psa, en = 1, er;
  logic psel_in = 0, penable_in = 0, pwrite_in = 0, ivalid, valid_out, dest_file_out;
  logic skip_test_out, shadow_save_out, pin_read_out, prescaler_clear_out, pready_out;
  logic pslverr_out, shadow_restore_out, tk [512] = '{default: 1'b0};
  logic [7:0] paddr_in = 8'h00, literal_out;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd, r;
  logic [15:0] instr;
  logic [11:0] file_addr_out, dst_addr_out;
  logic [19:0] target_out;
  logic [10:0] offset_out;
  logic [4:0] flag_mask_out;
  logic [3:0] bank_sel;
  logic [2:0] bit_pos_out;
  logic [1:0] cycles_out;
  logic [8:0] end_r = 9'h000;
  bod_op_t op_out;
  bod_exp_t eq [$], xe, e, no_operation;
  int seed = 19, n = 0, errors = 0, n_tests = 0, cyc = 0, n_emit = 0;
  // Byte opcodes in op order: {skip, fixed dest, flags, opcode}
  logic [15:0] tk_b [30] = '{16'h1f09, 16'h1f08, 16'h1f17, 16'h1f16, 16'h1f15, 16'h0505,
    16'h0504, 16'h0506, 16'h0507, 16'h0514, 16'h1f0a, 16'h1f01, 16'h400b, 16'h4013, 16'h400f,
    16'h4012, 16'h40b1, 16'h40b2, 16'h40b0, 16'h40b3, 16'h24b5, 16'h20b4, 16'h20b7, 16'h3fb6,
    16'h0081, 16'h150d, 16'h150c, 16'h0511, 16'h0510, 16'h000e};

  always #25 mclk_in = ~mclk_in;

  bod_prog_mem u_pm (.mclk_in, .rst_in, .ce_in, .end_in(end_r), .instr_out(instr),
    .valid_out(ivalid));
  bod_decoder uut (.mclk_in, .rst_in, .ce_in, .instr_in(instr), .instr_valid_in(ivalid),
    .taken_in, .valid_out, .op_out, .word_out(), .dest_file_out, .file_addr_out, .dst_addr_out,
    .bit_pos_out, .literal_out, .target_out, .offset_out, .flag_mask_out, .cycles_out,
    .skip_test_out, .shadow_save_out, .shadow_restore_out, .pin_read_out,
    .prescaler_clear_out, .paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out);

  function automatic bod_exp_t mk(bod_op_t op, int kd, logic [19:0] x, logic [1:0] cy);
    mk = '{op: op, kd: kd, x: x, cy: cy, default: '0};
  endfunction : mk

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic close_out();
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic put(input logic [15:0] w, input logic has, input bod_exp_t x);
    u_pm.mem[n] = w;
    n++;
    if (has) eq.push_back(en ? x : no_operation);
    if (has) n_emit++;
  endtask : put

  task automatic byte_op(input int i, input logic d, input logic a, input logic [7:0] f);
    bod_exp_t b;
    b = mk(bod_op_t'(6'(i + 1)), 0, 20'h0, 2'h1);
    b.m = tk_b[i][12:8];
    b.skp = tk_b[i][14];
    b.d = tk_b[i][7] ? tk_b[i][13] : d;
    b.fa = a ? {bank_sel, f} : {(f < 8'h60) ? 4'h0 : 4'hf, f};
    b.pin = b.d && b.fa[11:4] == 8'hf8 && !(i >= 20 && i <= 22);
    b.psc = b.d && b.fa == 12'hfd6 && psa;
    put(tk_b[i][7] ? {tk_b[i][6:0], a, f} : {tk_b[i][5:0], d, a, f}, 1'b1, b);
  endtask : byte_op

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    paddr_in <= a;
    pwrite_in <= w;
    pwdata_in <= wd;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do @(posedge mclk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  // Execute side: skip pulses and clock-enable gaps
  always @(posedge mclk_in) begin
    if (ce_in) taken_in <= tk[u_pm.ptr_r] && u_pm.ptr_r != end_r;
    ce_in <= rce ? (($random(seed) & 3) != 0) : 1'b1;
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end

  // Compare each answer with the model
  always @(posedge mclk_in) begin
    if (!rst_in && ce_in && valid_out === 1'b1) begin
      if (eq.size() == 0) chk(32'h1, 32'h0);
      else xe = eq.pop_front();
      chk(op_out, xe.op);
      if (xe.kd < 3 || xe.kd == 6) chk(flag_mask_out, xe.m);
      if (xe.kd < 3 || xe.kd == 7) chk(cycles_out, xe.cy);
      if (xe.kd == 0) chk(dest_file_out, xe.d);
      if (xe.kd < 2) chk(file_addr_out, xe.fa);
      if (xe.kd == 0) chk(skip_test_out, xe.skp);
      if (xe.kd == 0) chk(pin_read_out, xe.pin);
      if (xe.kd == 0) chk(prescaler_clear_out, xe.psc);
      if (xe.kd == 1) chk(dst_addr_out, xe.x[11:0]);
      if (xe.kd == 2) chk(target_out, xe.x);
      if (xe.kd == 2) chk(shadow_save_out, xe.sv);
      if (xe.kd == 7) chk(shadow_restore_out, xe.sv);
      if (xe.kd == 3) chk(offset_out, xe.x[10:0]);
      if (xe.kd == 4) chk(bit_pos_out, xe.x[2:0]);
      if (xe.kd == 5) chk(literal_out, xe.x[7:0]);
    end
  end

  initial begin
    no_operation = mk(OP_NOP, 6, 20'h0, 2'h1);
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_0200);
    apb(1'b0, 8'h0c, 32'h0);
    chk(er, 1'b1);
    for (int p = 0; p < 3; p++) begin
      bank_sel = 4'($random(seed));
      psa = p[0];
      en = p < 2;
      apb(1'b1, 8'h00, {22'h0, en, psa, 4'h0, bank_sel});
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, {22'h0, en, psa, 4'h0, bank_sel});
      for (int j = 0; j < 60; j++) begin
        r = $random(seed);
        byte_op(r[15:8] % 30, r[19], r[18], r[17:16] == 2'h0 ? {4'h8, r[3:0]} :
          r[17:16] == 2'h1 ? 8'hd6 : r[7:0]);
      end
      if (en) begin
        r = $random(seed);
        put({4'hc, r[11:0]}, 1'b0, no_operation);
        e = mk(OP_MOVE_FF, 1, {8'h00, r[27:16]}, 2'h2);
        e.fa = r[11:0];
        put({4'hf, r[27:16]}, 1'b1, e);
        put({8'hef, r[7:0]}, 1'b0, no_operation);
        put({4'hf, r[19:8]}, 1'b1, mk(OP_ABSOLUTE_JUMP, 2, r[19:0], 2'h2));
        put({8'h24, r[7:0]}, 1'b1, no_operation);
        e = mk(OP_CALL, 2, r[27:8], 2'h2);
        e.sv = r[31];
        put({7'h76, r[31], r[15:8]}, 1'b0, no_operation);
        put({4'hf, r[27:16]}, 1'b1, e);
        put({8'h24, r[7:0]}, 1'b1, no_operation);
        put({5'h1a, r[10:0]}, 1'b1, mk(OP_BRANCH, 3, {9'h0, r[10:0]}, 2'h2));
        put({8'h24, r[7:0]}, 1'b1, no_operation);
        put({5'h1c, r[18:8]}, 1'b1, mk(OP_BCOND, 3, {9'h0, {3{r[15]}}, r[15:8]}, 2'h1));
        put({4'h8 | {2'b00, r[13:12]}, r[11:0]}, 1'b1, mk(OP_BIT, 4, {17'h0, r[11:9]}, 2'h1));
        put({8'h0e, r[7:0]}, 1'b1, mk(OP_LIT, 5, {12'h0, r[7:0]}, 2'h1));
        put({4'hf, r[11:0]}, 1'b1, no_operation);
        e = mk(OP_RETURN, 7, 20'h0, 2'h2);
        e.sv = r[30];
        put({15'h0009, r[30]}, 1'b1, e);
        byte_op(16, 1'b0, 1'b0, r[7:0]);
        tk[n] = 1'b1;
        put({8'h24, r[7:0]}, 1'b1, no_operation);
        byte_op(19, 1'b0, 1'b0, r[7:0]);
        tk[n] = 1'b1;
        put({4'hc, r[11:0]}, 1'b1, no_operation);
        put({4'hf, r[23:12]}, 1'b1, no_operation);
      end
      rce <= 1'b1;
      end_r <= 9'(n);
      @(posedge mclk_in);
      while (eq.size() != 0 || u_pm.ptr_r != end_r) @(posedge mclk_in);
      rce <= 1'b0;
      repeat (4) @(posedge mclk_in);
    end
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'(n_emit));
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    chk(eq.size(), 32'h0);
    close_out();
  end
endmodule : tb
